// ==== core/ccu_pkg.sv ====
// package: register map, field layout and constants of the camera capture unit
package ccu_pkg;
  localparam logic [7:0] CCU_CTRL_OFS = 8'h00;
  localparam logic [7:0] CCU_EVENT_STATUS_OFS = 8'h08;
  localparam logic [7:0] CCU_IRQ_ENABLE_OFS = 8'h0c;
  localparam logic [7:0] CCU_IRQ_FLAGS_OFS = 8'h10;
  localparam logic [7:0] CCU_FLAG_CLEAR_OFS = 8'h14;
  localparam logic [7:0] CCU_SYNC_CODES_OFS = 8'h18;
  localparam logic [7:0] CCU_SYNC_MASK_OFS = 8'h1c;
  localparam logic [7:0] CCU_CROP_START_OFS = 8'h20;
  localparam logic [7:0] CCU_CROP_SIZE_OFS = 8'h24;
  localparam logic [7:0] CCU_PIXEL_WORD_OFS = 8'h28;
  localparam int CCU_FRAME_DONE_BIT = 0;
  localparam int CCU_OVERRUN_BIT = 1;
  localparam int CCU_SYNC_ERROR_BIT = 2;
  localparam int CCU_VBLANK_BIT = 3;
  localparam int CCU_LINE_DONE_BIT = 4;
  localparam int CCU_NFLAGS = 5;
  localparam int CCU_CODE_FS_LSB = 0;
  localparam int CCU_CODE_LS_LSB = 8;
  localparam int CCU_CODE_LE_LSB = 16;
  localparam int CCU_CODE_FE_LSB = 24;
  localparam int CCU_ROW_LSB = 16;
  localparam int CCU_ROW_START_W = 13;
  localparam int CCU_COL_W = 14;
  localparam int CCU_ROW_SIZE_W = 14;
  localparam int CCU_CTRL_CAPTURE_BIT = 0;
  localparam int CCU_CTRL_CROP_BIT = 1;
  localparam int CCU_CTRL_ESM_BIT = 2;
  localparam logic [31:0] CCU_RESET_WORD = 32'h0000_0000;
  localparam logic [7:0] CCU_SYNC_B0 = 8'hff;
  localparam logic [7:0] CCU_SYNC_B1 = 8'h00;
  localparam logic [1:0] CCU_RESP_OKAY = 2'b00;
  localparam logic [1:0] CCU_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    CCU_SY_IDLE,
    CCU_SY_FF,
    CCU_SY_Z1,
    CCU_SY_Z2
  } ccu_sync_t;
endpackage

// ==== core/ccu_capture_regs.sv ====
// camera capture unit: status/irq/sync/crop registers over axi4-lite, pixel side
`timescale 1ns/1ns
// Summary of operation
// - line done sets status bit 4, sticky
// - vertical blanking sets status bit 3
// - sync decode error sets status bit 2
// - word push while fifo full sets bit 1
// - frame done sets status bit 0
// - five enables gate flags, same positions
// - read-only irq flags equal flag and enable
// - write one clears flag and irq flag
// - four 8-bit sync codes in byte lanes
// - per-code unmask bits select compared bits
// - 13-bit row start, zero first line
// - 14-bit column start, zero first clock
// - row size field holds lines minus one
// - column size field holds width minus one
// - word access; byte 0 earliest pixel
// - any enabled flag drives the interrupt
// - sync code is ff 00 00 code
// - only pixels inside crop window kept
module ccu_capture_regs
  import ccu_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic pix_clk_in,
  input wire logic [7:0] pix_data_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic fifo_full_in,
  output logic [31:0] fifo_word_out,
  output logic fifo_push_out,
  output logic irq_out
);
  // two-stage synchronisers for all pin-side inputs
  logic [11:0] pin_s1_r;
  logic [11:0] pin_s2_r;
  logic pclk_d_r;
  logic hs_d_r;
  logic vs_d_r;

  logic [31:0] ctrl_r;
  logic [4:0] status_r;
  logic [4:0] irq_en_r;
  logic [31:0] sync_codes_r;
  logic [31:0] sync_mask_r;
  logic [31:0] crop_start_r;
  logic [31:0] crop_size_r;
  logic [31:0] pixel_word_r;

  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic [13:0] col_r;
  logic [13:0] row_r;
  logic [1:0] byte_idx_r;
  logic [31:0] pack_r;
  logic push_r;
  logic [31:0] push_word_r;
  logic line_active_r;
  ccu_sync_t sync_st_r;
  ccu_sync_t sync_st_nxt;

  // pin sampling; pclk edge detected in system clock
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      pin_s1_r <= 12'h000;
      pin_s2_r <= 12'h000;
      pclk_d_r <= 1'b0;
      hs_d_r <= 1'b0;
      vs_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {vsync_in, hsync_in, pix_clk_in, fifo_full_in, pix_data_in};
      pin_s2_r <= pin_s1_r;
      pclk_d_r <= pin_s2_r[9];
      hs_d_r <= pin_s2_r[10];
      vs_d_r <= pin_s2_r[11];
    end
  end

  wire logic [7:0] pdata = pin_s2_r[7:0];
  wire logic pfull = pin_s2_r[8];
  wire logic pclk_rise = pin_s2_r[9] & ~pclk_d_r;
  wire logic hs_now = pin_s2_r[10];
  wire logic vs_now = pin_s2_r[11];
  wire logic capture_on = ctrl_r[CCU_CTRL_CAPTURE_BIT];
  wire logic crop_on = ctrl_r[CCU_CTRL_CROP_BIT];
  wire logic esm_on = ctrl_r[CCU_CTRL_ESM_BIT];

  // compare only unmasked bits of a received code byte
  function automatic logic code_hit(input logic [7:0] rx, input logic [7:0] code,
                                    input logic [7:0] mask);
    code_hit = ((rx ^ code) & mask) == 8'h00;
  endfunction

  // embedded sync: ff 00 00 then code byte
  wire logic code_slot = pclk_rise & (sync_st_r == CCU_SY_Z2);
  wire logic hit_fs = code_slot & code_hit(pdata, sync_codes_r[CCU_CODE_FS_LSB +: 8],
                                           sync_mask_r[CCU_CODE_FS_LSB +: 8]);
  wire logic hit_ls = code_slot & code_hit(pdata, sync_codes_r[CCU_CODE_LS_LSB +: 8],
                                           sync_mask_r[CCU_CODE_LS_LSB +: 8]);
  wire logic hit_le = code_slot & code_hit(pdata, sync_codes_r[CCU_CODE_LE_LSB +: 8],
                                           sync_mask_r[CCU_CODE_LE_LSB +: 8]);
  wire logic hit_fe = code_slot & code_hit(pdata, sync_codes_r[CCU_CODE_FE_LSB +: 8],
                                           sync_mask_r[CCU_CODE_FE_LSB +: 8]);
  wire logic sync_bad = esm_on & code_slot & ~(hit_fs | hit_ls | hit_le | hit_fe);

  always_comb begin
    sync_st_nxt = sync_st_r;
    if (pclk_rise) begin
      case (sync_st_r)
        CCU_SY_IDLE: sync_st_nxt = (pdata == CCU_SYNC_B0) ? CCU_SY_FF : CCU_SY_IDLE;
        CCU_SY_FF: sync_st_nxt = (pdata == CCU_SYNC_B1) ? CCU_SY_Z1 : CCU_SY_IDLE;
        CCU_SY_Z1: sync_st_nxt = (pdata == CCU_SYNC_B1) ? CCU_SY_Z2 : CCU_SY_IDLE;
        CCU_SY_Z2: sync_st_nxt = CCU_SY_IDLE;
        default: sync_st_nxt = CCU_SY_IDLE;
      endcase
    end
    if (!esm_on) begin
      sync_st_nxt = CCU_SY_IDLE;
    end
  end

  // line and frame boundaries from pins or from codes
  wire logic line_start = esm_on ? hit_ls : (hs_now & ~hs_d_r);
  wire logic line_end = esm_on ? hit_le : (~hs_now & hs_d_r);
  wire logic frame_start = esm_on ? hit_fs : (~vs_now & vs_d_r);
  wire logic frame_end = esm_on ? hit_fe : (vs_now & ~vs_d_r);
  wire logic in_code = esm_on & ((sync_st_r != CCU_SY_IDLE) | (pdata == CCU_SYNC_B0));
  wire logic pix_valid = pclk_rise & line_active_r & ~in_code & capture_on;

  // crop window: start position plus size-minus-one
  wire logic [13:0] row_lo = {1'b0, crop_start_r[CCU_ROW_LSB +: CCU_ROW_START_W]};
  wire logic [13:0] col_lo = crop_start_r[CCU_COL_W-1:0];
  wire logic [14:0] row_hi = 15'(row_lo) + 15'(crop_size_r[CCU_ROW_LSB +: CCU_ROW_SIZE_W]);
  wire logic [14:0] col_hi = 15'(col_lo) + 15'(crop_size_r[CCU_COL_W-1:0]);
  wire logic in_win = (row_r >= row_lo) & (15'(row_r) <= row_hi) &
                      (col_r >= col_lo) & (15'(col_r) <= col_hi);
  wire logic keep_pix = pix_valid & (~crop_on | in_win);
  wire logic word_full = keep_pix & (byte_idx_r == 2'd3);
  wire logic want_push = word_full | (line_end & (byte_idx_r != 2'd0) & capture_on);
  wire logic [31:0] pack_next = pack_r | (32'(pdata) << {byte_idx_r, 3'b000});

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sync_st_r <= CCU_SY_IDLE;
      line_active_r <= 1'b0;
      col_r <= 14'h0000;
      row_r <= 14'h0000;
    end else begin
      sync_st_r <= sync_st_nxt;
      if (line_start) begin
        line_active_r <= 1'b1;
      end else if (line_end | frame_end) begin
        line_active_r <= 1'b0;
      end
      if (line_start) begin
        col_r <= 14'h0000;
      end else if (pix_valid) begin
        col_r <= col_r + 14'h0001;
      end
      if (frame_start) begin
        row_r <= 14'h0000;
      end else if (line_end & line_active_r) begin
        row_r <= row_r + 14'h0001;
      end
    end
  end

  // byte packing, earliest pixel in the low lane
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      byte_idx_r <= 2'd0;
      pack_r <= CCU_RESET_WORD;
      push_r <= 1'b0;
      push_word_r <= CCU_RESET_WORD;
    end else begin
      push_r <= want_push & ~pfull;
      // a refused word is dropped, so the output word only moves with a push
      if (want_push & ~pfull) begin
        push_word_r <= word_full ? pack_next : pack_r;
      end
      if (want_push) begin
        byte_idx_r <= 2'd0;
        pack_r <= CCU_RESET_WORD;
      end else if (keep_pix) begin
        byte_idx_r <= byte_idx_r + 2'd1;
        pack_r <= pack_next;
      end
    end
  end

  // axi4-lite write path: address and data accepted in either order
  // take only on a real valid and ready handshake, never before ready rises
  wire logic aw_take = s_axi_awvalid_in & s_axi_awready_out;
  wire logic w_take = s_axi_wvalid_in & s_axi_wready_out;
  wire logic aw_have = aw_held_r | aw_take;
  wire logic w_have = w_held_r | w_take;
  wire logic wr_fire = aw_have & w_have & ~bvalid_r;
  wire logic [7:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr_in;
  wire logic [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata_in;
  wire logic [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb_in;
  wire logic wr_full = wr_strb == 4'hf;
  wire logic wr_ok = wr_fire & wr_full;
  wire logic wr_map = (wr_addr == CCU_CTRL_OFS) | (wr_addr == CCU_IRQ_ENABLE_OFS) |
                      (wr_addr == CCU_FLAG_CLEAR_OFS) | (wr_addr == CCU_SYNC_CODES_OFS) |
                      (wr_addr == CCU_SYNC_MASK_OFS) | (wr_addr == CCU_CROP_START_OFS) |
                      (wr_addr == CCU_CROP_SIZE_OFS);
  wire logic [4:0] clr_bits = (wr_ok & (wr_addr == CCU_FLAG_CLEAR_OFS)) ?
                              wr_data[CCU_NFLAGS-1:0] : 5'h00;

  // hardware events; set wins over a simultaneous clear
  wire logic [4:0] set_bits = {line_end & line_active_r & capture_on,
                               frame_end & capture_on,
                               sync_bad,
                               want_push & pfull,
                               frame_end & capture_on & (row_r != 14'h0000)};
  wire logic [4:0] status_nxt = set_bits | (status_r & ~clr_bits);
  wire logic [4:0] irq_flags = status_r & irq_en_r;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= CCU_RESET_WORD;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= CCU_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wr_map & wr_full) ? CCU_RESP_OKAY : CCU_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_r <= 1'b1;
          awaddr_r <= s_axi_awaddr_in;
        end
        if (w_take) begin
          w_held_r <= 1'b1;
          wdata_r <= s_axi_wdata_in;
          wstrb_r <= s_axi_wstrb_in;
        end
        if (bvalid_r & s_axi_bready_in) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // register storage; reserved bits kept at zero
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_r <= CCU_RESET_WORD;
      status_r <= 5'h00;
      irq_en_r <= 5'h00;
      sync_codes_r <= CCU_RESET_WORD;
      sync_mask_r <= CCU_RESET_WORD;
      crop_start_r <= CCU_RESET_WORD;
      crop_size_r <= CCU_RESET_WORD;
      pixel_word_r <= CCU_RESET_WORD;
    end else begin
      status_r <= status_nxt;
      if (want_push & ~pfull) begin
        pixel_word_r <= word_full ? pack_next : pack_r;
      end
      if (wr_ok & (wr_addr == CCU_CTRL_OFS)) begin
        ctrl_r <= {29'h0, wr_data[2:0]};
      end
      if (wr_ok & (wr_addr == CCU_IRQ_ENABLE_OFS)) begin
        irq_en_r <= wr_data[CCU_NFLAGS-1:0];
      end
      if (wr_ok & (wr_addr == CCU_SYNC_CODES_OFS)) begin
        sync_codes_r <= wr_data;
      end
      if (wr_ok & (wr_addr == CCU_SYNC_MASK_OFS)) begin
        sync_mask_r <= wr_data;
      end
      if (wr_ok & (wr_addr == CCU_CROP_START_OFS)) begin
        crop_start_r <= wr_data & 32'h1fff_3fff;
      end
      if (wr_ok & (wr_addr == CCU_CROP_SIZE_OFS)) begin
        crop_size_r <= wr_data & 32'h3fff_3fff;
      end
    end
  end

  // axi4-lite read path, one read at a time
  wire logic ar_take = s_axi_arvalid_in & s_axi_arready_out;
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = CCU_RESET_WORD;
    rd_hit = 1'b1;
    case (s_axi_araddr_in)
      CCU_CTRL_OFS: rd_mux = ctrl_r;
      CCU_EVENT_STATUS_OFS: rd_mux = {27'h0, status_r};
      CCU_IRQ_ENABLE_OFS: rd_mux = {27'h0, irq_en_r};
      CCU_IRQ_FLAGS_OFS: rd_mux = {27'h0, irq_flags};
      CCU_FLAG_CLEAR_OFS: rd_mux = CCU_RESET_WORD;
      CCU_SYNC_CODES_OFS: rd_mux = sync_codes_r;
      CCU_SYNC_MASK_OFS: rd_mux = sync_mask_r;
      CCU_CROP_START_OFS: rd_mux = crop_start_r;
      CCU_CROP_SIZE_OFS: rd_mux = crop_size_r;
      CCU_PIXEL_WORD_OFS: rd_mux = pixel_word_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= CCU_RESET_WORD;
      rresp_r <= CCU_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? CCU_RESP_OKAY : CCU_RESP_SLVERR;
    end else if (rvalid_r & s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

  // ready outputs registered: high whenever a new item may be taken next cycle
  logic awready_r;
  logic wready_r;
  logic arready_r;
  logic irq_r;
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      irq_r <= |(status_nxt & irq_en_r);
    end
  end

  // ready is qualified by held state so an item is never taken twice
  assign s_axi_awready_out = awready_r & ~aw_held_r & ~bvalid_r;
  assign s_axi_wready_out = wready_r & ~w_held_r & ~bvalid_r;
  assign s_axi_arready_out = arready_r & ~rvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign fifo_word_out = push_word_r;
  assign fifo_push_out = push_r;
  assign irq_out = irq_r;
endmodule

// ==== testbench/ccu_checker.sv ====
// checker: bus answer and pixel push relations at the capture unit ports
`timescale 1ns/1ns
module ccu_checker
  import ccu_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic fifo_full_in,
  input wire logic [31:0] fifo_word_out,
  input wire logic fifo_push_out,
  input wire logic irq_out
);
  wire logic aw_w_take = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in;
  wire logic ar_take = s_axi_arvalid_in && s_axi_arready_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  a_bresp_held: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped before bready");
  a_rdata_held: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> $stable(s_axi_rdata_out))
    else $error("read data changed before rready");
  a_bad_strobe: assert property (aw_w_take && s_axi_wready_out && s_axi_wstrb_in != 4'hf
    |-> ##[1:2] (s_axi_bvalid_out && s_axi_bresp_out == CCU_RESP_SLVERR))
    else $error("partial strobe write not refused");
  a_clear_reads_zero: assert property (ar_take && s_axi_araddr_in == CCU_FLAG_CLEAR_OFS
    |-> ##[1:2] (s_axi_rvalid_out && s_axi_rdata_out == 32'h0))
    else $error("flag clear register read not zero");
  a_unmapped_read: assert property (ar_take && s_axi_araddr_in == 8'h40
    |-> ##[1:2] (s_axi_rvalid_out && s_axi_rresp_out == CCU_RESP_SLVERR))
    else $error("unmapped read not refused");
  a_push_pulse: assert property (fifo_push_out |=> !fifo_push_out)
    else $error("push longer than one cycle");
  a_word_on_push: assert property ($changed(fifo_word_out) |-> fifo_push_out)
    else $error("pixel word changed without push");
  a_full_no_push: assert property (fifo_full_in [*4] |-> !fifo_push_out)
    else $error("push while fifo full");
  a_aw_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  c_push: cover property (fifo_push_out);
  c_irq: cover property ($rose(irq_out));
  c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == CCU_RESP_SLVERR);
endmodule

// ==== testbench/ccu_sensor_model.sv ====
// partner model: image sensor driving pixel clock, pixel byte and sync lines
`timescale 1ns/1ns
module ccu_sensor_model (
  output logic pix_clk_out,
  output logic [7:0] pix_data_out,
  output logic hsync_out,
  output logic vsync_out
);
  initial begin
    pix_clk_out = 1'b0;
    pix_data_out = 8'h5a;
    hsync_out = 1'b0;
    vsync_out = 1'b0;
  end
  // clock stands low between transfers; the 13 ns offset keeps edges off the system clock
  task automatic byte_tx(input logic [7:0] d);
    pix_data_out = d;
    #400 pix_clk_out = 1'b1;
    #400 pix_clk_out = 1'b0;
  endtask
  task automatic line_tx(input logic [31:0] w);
    #13 hsync_out = 1'b1;
    #400;
    for (int i = 0; i < 4; i++) byte_tx(w[8*i+:8]);
    #400 hsync_out = 1'b0;
    // released bus shows the inverse so a stale byte cannot pass
    pix_data_out = ~w[31:24];
  endtask
  task automatic code_tx(input logic [7:0] c);
    #13;
    byte_tx(8'hff);
    byte_tx(8'h00);
    byte_tx(8'h00);
    byte_tx(c);
    pix_data_out = ~c;
  endtask
  task automatic vs_tx(input logic l);
    #13 vsync_out = l;
    #800;
  endtask
endmodule

// ==== testbench/tb.sv ====
// testbench: register access, line and frame capture, overrun, crop and sync code scenarios
`timescale 1ns/1ns
module tb;
  import ccu_pkg::*;
  logic clock_in;
  logic reset_in;
  logic [7:0] s_axi_awaddr_in;
  logic s_axi_awvalid_in;
  logic s_axi_awready_out;
  logic [31:0] s_axi_wdata_in;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_wvalid_in;
  logic s_axi_wready_out;
  logic [1:0] s_axi_bresp_out;
  logic s_axi_bvalid_out;
  logic s_axi_bready_in;
  logic [7:0] s_axi_araddr_in;
  logic s_axi_arvalid_in;
  logic s_axi_arready_out;
  logic [31:0] s_axi_rdata_out;
  logic [1:0] s_axi_rresp_out;
  logic s_axi_rvalid_out;
  logic s_axi_rready_in;
  logic pix_clk_in;
  logic [7:0] pix_data_in;
  logic hsync_in;
  logic vsync_in;
  logic fifo_full_in;
  logic [31:0] fifo_word_out;
  logic fifo_push_out;
  logic irq_out;
  int n_fail = 0;
  int total_checks = 0;
  int n_push = 0;
  logic [31:0] last_word = 32'h0;
  logic [31:0] rd;
  logic [1:0] rsp;
  ccu_capture_regs ccu_capture_regs_i (.*);
  ccu_sensor_model ccu_sensor_model_i (.pix_clk_out(pix_clk_in), .pix_data_out(pix_data_in),
    .hsync_out(hsync_in), .vsync_out(vsync_in));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (fifo_push_out === 1'b1) begin
      n_push++;
      last_word = fifo_word_out;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // ready is raised a cycle late on purpose, so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    // sensor tasks return between edges; start the request right after an edge
    @(posedge clock_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out === 1'b1 && !s_axi_bready_in) s_axi_bready_in <= 1'b1;
    end while (!(s_axi_bvalid_out === 1'b1 && s_axi_bready_in));
    rsp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd_word(input logic [7:0] a);
    @(posedge clock_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out === 1'b1 && !s_axi_rready_in) s_axi_rready_in <= 1'b1;
    end while (!(s_axi_rvalid_out === 1'b1 && s_axi_rready_in));
    rd = s_axi_rdata_out;
    rsp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    rd_word(a);
    chk(what, e, rd);
  endtask
  task automatic t_regs();
    logic [7:0] ofs [5] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h0c};
    logic [31:0] val [5] = '{32'hb69d_80ab, 32'hf00f_55aa, 32'h1fff_3fff, 32'h3fff_3fff, 32'h1f};
    for (int i = 0; i < 9; i++) rchk("reset", 8'h08 + 8'(4 * i), CCU_RESET_WORD);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], val[i]);
      rchk("readback", ofs[i], val[i]);
    end
    wr(CCU_IRQ_ENABLE_OFS, 32'h0, 4'h3);
    chk("strobe resp", 32'(CCU_RESP_SLVERR), 32'(rsp));
    rchk("enable kept", CCU_IRQ_ENABLE_OFS, 32'h0000_001f);
    wr(CCU_EVENT_STATUS_OFS, 32'h0000_001f);
    chk("ro write resp", 32'(CCU_RESP_SLVERR), 32'(rsp));
    rd_word(8'h40);
    chk("unmapped resp", 32'(CCU_RESP_SLVERR), 32'(rsp));
    wr(CCU_IRQ_ENABLE_OFS, 32'h0);
    wr(CCU_CROP_START_OFS, 32'h0000_0001);
    wr(CCU_CROP_SIZE_OFS, 32'h0000_0001);
  endtask
  task automatic t_frame();
    wr(CCU_CTRL_OFS, 32'h0000_0001);
    ccu_sensor_model_i.vs_tx(1'b1);
    ccu_sensor_model_i.vs_tx(1'b0);
    wr(CCU_FLAG_CLEAR_OFS, 32'h0000_001f);
    ccu_sensor_model_i.line_tx(32'h4433_2211);
    tick(8);
    chk("pushed word", 32'h4433_2211, last_word);
    rchk("pixel word", CCU_PIXEL_WORD_OFS, 32'h4433_2211);
    rchk("status", CCU_EVENT_STATUS_OFS, 32'h0000_0010);
    ccu_sensor_model_i.vs_tx(1'b1);
    tick(8);
    rchk("status", CCU_EVENT_STATUS_OFS, 32'h0000_0019);
    rchk("flags", CCU_IRQ_FLAGS_OFS, 32'h0);
    chk("irq", 32'h0, 32'(irq_out));
    wr(CCU_IRQ_ENABLE_OFS, 32'h0000_0001);
    chk("irq", 32'h1, 32'(irq_out));
    rchk("flags", CCU_IRQ_FLAGS_OFS, 32'h0000_0001);
    wr(CCU_FLAG_CLEAR_OFS, 32'h0000_0006);
    rchk("status", CCU_EVENT_STATUS_OFS, 32'h0000_0019);
    wr(CCU_FLAG_CLEAR_OFS, 32'h0000_0001);
    chk("irq", 32'h0, 32'(irq_out));
    rchk("status", CCU_EVENT_STATUS_OFS, 32'h0000_0018);
    ccu_sensor_model_i.vs_tx(1'b0);
    wr(CCU_FLAG_CLEAR_OFS, 32'h0000_001f);
  endtask
  task automatic t_overrun();
    int p;
    p = n_push;
    fifo_full_in <= 1'b1;
    ccu_sensor_model_i.line_tx(32'h8877_6655);
    tick(8);
    fifo_full_in <= 1'b0;
    chk("push count", 32'(p), 32'(n_push));
    rchk("status", CCU_EVENT_STATUS_OFS, 32'h0000_0012);
    wr(CCU_FLAG_CLEAR_OFS, 32'h0000_001f);
  endtask
  task automatic t_crop();
    int p;
    wr(CCU_CTRL_OFS, 32'h0000_0003);
    ccu_sensor_model_i.vs_tx(1'b1);
    ccu_sensor_model_i.vs_tx(1'b0);
    p = n_push;
    ccu_sensor_model_i.line_tx(32'hddcc_bbaa);
    ccu_sensor_model_i.line_tx(32'h1122_3344);
    tick(8);
    chk("push count", 32'(p + 1), 32'(n_push));
    chk("crop word", 32'h0000_ccbb, last_word);
    wr(CCU_FLAG_CLEAR_OFS, 32'h0000_001f);
  endtask
  task automatic t_embed();
    wr(CCU_SYNC_MASK_OFS, 32'hffff_ffff);
    wr(CCU_CTRL_OFS, 32'h0000_0005);
    ccu_sensor_model_i.code_tx(8'h7e);
    tick(8);
    rd_word(CCU_EVENT_STATUS_OFS);
    chk("sync error", 32'h0000_0004, rd & 32'h0000_0004);
    wr(CCU_FLAG_CLEAR_OFS, 32'h0000_001f);
    wr(CCU_SYNC_MASK_OFS, 32'hffff_f0ff);
    ccu_sensor_model_i.code_tx(8'h8c);
    tick(8);
    rd_word(CCU_EVENT_STATUS_OFS);
    chk("sync error", 32'h0, rd & 32'h0000_0004);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    reset_in <= 1'b1;
    s_axi_awaddr_in <= 8'h00;
    s_axi_awvalid_in <= 1'b0;
    s_axi_wdata_in <= 32'h0;
    s_axi_wstrb_in <= 4'hf;
    s_axi_wvalid_in <= 1'b0;
    s_axi_bready_in <= 1'b0;
    s_axi_araddr_in <= 8'h00;
    s_axi_arvalid_in <= 1'b0;
    s_axi_rready_in <= 1'b0;
    fifo_full_in <= 1'b0;
    tick(2);
    reset_in <= 1'b0;
    tick(1);
    t_regs();
    t_frame();
    t_overrun();
    t_crop();
    t_embed();
    end_sim();
  end
  initial begin
    #2_000_000;
    n_fail++;
    end_sim();
  end
endmodule
bind ccu_capture_regs ccu_checker ccu_checker_i (.*);
